//--- hdl/gdc_defs.svh
// Purpose: constants of the decoder global control block
// Assumes: one 8-bit control register at offset 0x00
// Notes: included by the package and the gdc_global_ctrl module
// Contract
// - soft run bit low resets, holds state machines and disables outputs.
// - soft run bit high starts state machines and enables outputs.
// - soft run bit ignored while pin reset linkage bit is high.
// - linkage high and reset pin low force soft run low, hold machines.
// - linkage low: pin release leaves machines stopped until soft run written high.
// - linkage high: machines restart as soon as reset pin returns high.
// - three-bit action field picks behaviour on low action pin.
// - code 000 resets and holds outputs, state machines and burst loop; the code tristates the outputs instead of holding them.
// - code 001 forces blue or colour output, machines and loop flywheel.
// - 010 holds outputs, locks external; 011 resets loop; 100 resets both.
// - code 101 forces blue output, locks machines and loop to video.
// - code 110 triggers line and pixel grab per grab control register.
// - code 111 toggles between normal running and code 010 per pulse.
// - first code 111 pulse after any reset enters code 010 behaviour.
// - sync disable bit high disables decoder line and field sync outputs.
// - standard field 00 NTSC, 10 PAL/M, 11 other PAL, 01 reserved.
`ifndef GDC_DEFS_SVH
`define GDC_DEFS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define GDC_ADDR_W 8
`define GDC_DATA_W 8
`define GDC_OFS_CTRL 8'h00
`define GDC_CTRL_RESET 8'h00

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define GDC_BIT_SOFT_RUN 7
`define GDC_BIT_LINKAGE 6
`define GDC_ACT_HI 5
`define GDC_ACT_LO 3
`define GDC_BIT_SYNC_DIS 2
`define GDC_STD_HI 1
`define GDC_STD_LO 0

// ---------------------------------------------------------------
// action codes and standards
// ---------------------------------------------------------------
`define GDC_ACT_RESET_ALL 3'h0
`define GDC_ACT_FLYWHEEL 3'h1
`define GDC_ACT_HOLD_LOCK 3'h2
`define GDC_ACT_RESET_BLL 3'h3
`define GDC_ACT_RESET_SM 3'h4
`define GDC_ACT_BLUE_LOCK 3'h5
`define GDC_ACT_GRAB 3'h6
`define GDC_ACT_TOGGLE 3'h7
`define GDC_STD_NTSC 2'h0
`define GDC_STD_RSVD 2'h1
`define GDC_STD_PALM 2'h2
`define GDC_STD_PAL 2'h3

`endif

//--- hdl/gdc_pkg.sv
// Purpose: types of the decoder global control block
// Assumes: gdc_defs.svh holds the numbers
// Notes: one-hot mode codes
`include "gdc_defs.svh"

package gdc_pkg;

  // effective behaviour after pin and toggle decode
  typedef enum logic [8:0] {
    GDC_MODE_NORMAL = 9'h001,
    GDC_MODE_RESET_ALL = 9'h002,
    GDC_MODE_FLYWHEEL = 9'h004,
    GDC_MODE_HOLD_LOCK = 9'h008,
    GDC_MODE_RESET_BLL = 9'h010,
    GDC_MODE_RESET_SM = 9'h020,
    GDC_MODE_BLUE_LOCK = 9'h040,
    GDC_MODE_GRAB = 9'h080,
    GDC_MODE_STOPPED = 9'h100
  } gdc_mode_e;

  typedef logic [2:0] gdc_action_t;

endpackage : gdc_pkg

//--- hdl/gdc_sync2.sv
// Purpose: two-flop synchroniser for a pin
// Assumes: pin idles high
// Notes: first stage read only by second stage
`timescale 1ns/1ps
`default_nettype none

module gdc_sync2 (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // pin and synchronised level
  input wire logic pin_i,
  output logic level_o
);

  logic meta_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_reg <= 1'b1;
      level_o <= 1'b1;
    end else begin
      meta_reg <= pin_i;
      level_o <= meta_reg;
    end
  end

endmodule // gdc_sync2

`default_nettype wire

//--- hdl/gdc_fall_detect.sv
// Purpose: one-cycle pulse on a falling level
// Assumes: level already synchronised to clk_i
// Notes: pulse is registered
`timescale 1ns/1ps
`default_nettype none

module gdc_fall_detect (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // level in, pulse out
  input wire logic level_i,
  output logic fall_o
);

  logic last_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      last_reg <= 1'b1;
      fall_o <= 1'b0;
    end else begin
      last_reg <= level_i;
      fall_o <= last_reg & ~level_i;
    end
  end

endmodule // gdc_fall_detect

`default_nettype wire

//--- hdl/gdc_global_ctrl.sv
// Purpose: global reset and action pin control of the video decoder
// Assumes: host port on clk_i; reset and action pins asynchronous, active low
// Notes: all outputs registered; control state one cycle behind the pins' sync
`timescale 1ns/1ps
`default_nettype none
`include "gdc_defs.svh"

module gdc_global_ctrl
  import gdc_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // register port
  input wire logic [`GDC_ADDR_W-1:0] addr_i,
  input wire logic [`GDC_DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`GDC_DATA_W-1:0] rd_data_o,
  // device pins
  input wire logic reset_pin_n_i,
  input wire logic action_pin_n_i,
  // core side
  input wire logic ycbcr_mode_i,
  input wire logic line_sync_i,
  input wire logic field_sync_i,
  // state machine control
  output logic sm_reset_o,
  output logic sm_flywheel_o,
  output logic sm_lock_ext_o,
  output logic sm_lock_video_o,
  // burst loop control
  output logic bll_reset_o,
  output logic bll_flywheel_o,
  output logic bll_lock_ext_o,
  output logic bll_lock_video_o,
  // output stage control
  output logic out_tristate_o,
  output logic out_hold_o,
  output logic out_force_blue_o,
  output logic out_force_color_o,
  output logic grab_trigger_o,
  // syncs and static settings
  output logic decoder_line_sync_out_o,
  output logic decoder_field_sync_out_o,
  output logic sync_output_disable_o,
  output logic [1:0] video_standard_select_o,
  output logic toggle_active_o
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic gdc_mode_e gdc_decode(input gdc_action_t code, input logic act_low,
                                           input logic tog);
    gdc_mode_e m;
    m = GDC_MODE_NORMAL;
    if (code == `GDC_ACT_TOGGLE) begin
      m = tog ? GDC_MODE_HOLD_LOCK : GDC_MODE_NORMAL;
    end else if (act_low) begin
      case (code)
        `GDC_ACT_RESET_ALL: m = GDC_MODE_RESET_ALL;
        `GDC_ACT_FLYWHEEL: m = GDC_MODE_FLYWHEEL;
        `GDC_ACT_HOLD_LOCK: m = GDC_MODE_HOLD_LOCK;
        `GDC_ACT_RESET_BLL: m = GDC_MODE_RESET_BLL;
        `GDC_ACT_RESET_SM: m = GDC_MODE_RESET_SM;
        `GDC_ACT_BLUE_LOCK: m = GDC_MODE_BLUE_LOCK;
        `GDC_ACT_GRAB: m = GDC_MODE_GRAB;
        default: m = GDC_MODE_NORMAL;
      endcase
    end
    return m;
  endfunction

  function automatic logic gdc_is_ctrl(input logic [`GDC_ADDR_W-1:0] a);
    return a == `GDC_OFS_CTRL;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic reset_pin_s;
  logic action_pin_s;
  logic action_fall;

  gdc_sync2 u_sync_reset (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(reset_pin_n_i),
    .level_o(reset_pin_s)
  );

  gdc_sync2 u_sync_action (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .pin_i(action_pin_n_i),
    .level_o(action_pin_s)
  );

  gdc_fall_detect u_fall_action (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .level_i(action_pin_s),
    .fall_o(action_fall)
  );

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  logic soft_run_bit_reg;
  logic pin_reset_linkage_bit_reg;
  gdc_action_t action_reg;
  logic sync_disable_reg;
  logic [1:0] std_reg;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      soft_run_bit_reg <= 1'(`GDC_CTRL_RESET >> `GDC_BIT_SOFT_RUN);
      pin_reset_linkage_bit_reg <= 1'b0;
      action_reg <= 3'h0;
      sync_disable_reg <= 1'b0;
      std_reg <= 2'h0;
    end else begin
      if (wr_i && gdc_is_ctrl(addr_i)) begin
        soft_run_bit_reg <= wr_data_i[`GDC_BIT_SOFT_RUN];
        pin_reset_linkage_bit_reg <= wr_data_i[`GDC_BIT_LINKAGE];
        action_reg <= wr_data_i[`GDC_ACT_HI:`GDC_ACT_LO];
        sync_disable_reg <= wr_data_i[`GDC_BIT_SYNC_DIS];
        std_reg <= wr_data_i[`GDC_STD_HI:`GDC_STD_LO];
      end
      // pin low clears the run bit, winning over a write
      if (!reset_pin_s) begin
        soft_run_bit_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_i && gdc_is_ctrl(addr_i)) begin
      rd_data_o <= {soft_run_bit_reg, pin_reset_linkage_bit_reg, action_reg, sync_disable_reg, std_reg};
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  // ---------------------------------------------------------------
  // run decision and toggle
  // ---------------------------------------------------------------
  logic run;
  logic toggle_reg;
  gdc_mode_e mode;

  // linkage high: pin alone decides; low: pin release waits for the run bit
  assign run = pin_reset_linkage_bit_reg ? reset_pin_s : (soft_run_bit_reg & reset_pin_s);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      toggle_reg <= 1'b0;
    end else if (!run) begin
      toggle_reg <= 1'b0;
    end else if (action_fall && action_reg == `GDC_ACT_TOGGLE) begin
      toggle_reg <= ~toggle_reg;
    end
  end

  assign mode = run ? gdc_decode(action_reg, ~action_pin_s, toggle_reg) : GDC_MODE_STOPPED;

  // ---------------------------------------------------------------
  // output decode
  // ---------------------------------------------------------------
  logic sm_reset_next;
  logic sm_fly_next;
  logic sm_ext_next;
  logic sm_vid_next;
  logic bll_reset_next;
  logic bll_fly_next;
  logic bll_ext_next;
  logic bll_vid_next;
  logic tri_next;
  logic hold_next;
  logic blue_next;
  logic color_next;

  always_comb begin
    sm_reset_next = 1'b0;
    sm_fly_next = 1'b0;
    sm_ext_next = 1'b0;
    sm_vid_next = 1'b0;
    bll_reset_next = 1'b0;
    bll_fly_next = 1'b0;
    bll_ext_next = 1'b0;
    bll_vid_next = 1'b0;
    tri_next = 1'b0;
    hold_next = 1'b0;
    blue_next = 1'b0;
    color_next = 1'b0;
    case (mode)
      GDC_MODE_STOPPED: begin
        sm_reset_next = 1'b1;
        tri_next = 1'b1;
      end
      GDC_MODE_RESET_ALL: begin
        tri_next = 1'b1;
        sm_reset_next = 1'b1;
        bll_reset_next = 1'b1;
      end
      GDC_MODE_FLYWHEEL: begin
        blue_next = ~ycbcr_mode_i;
        color_next = ycbcr_mode_i;
        sm_fly_next = 1'b1;
        bll_fly_next = 1'b1;
      end
      GDC_MODE_HOLD_LOCK: begin
        hold_next = 1'b1;
        sm_ext_next = 1'b1;
        bll_ext_next = 1'b1;
      end
      GDC_MODE_RESET_BLL: begin
        bll_reset_next = 1'b1;
      end
      GDC_MODE_RESET_SM: begin
        sm_reset_next = 1'b1;
        bll_reset_next = 1'b1;
      end
      GDC_MODE_BLUE_LOCK: begin
        blue_next = 1'b1;
        sm_vid_next = 1'b1;
        bll_vid_next = 1'b1;
      end
      GDC_MODE_NORMAL, GDC_MODE_GRAB: begin
        sm_reset_next = 1'b0;
      end
      default: begin
        sm_reset_next = 1'b1;
        tri_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sm_reset_o <= 1'b1;
      sm_flywheel_o <= 1'b0;
      sm_lock_ext_o <= 1'b0;
      sm_lock_video_o <= 1'b0;
      bll_reset_o <= 1'b0;
      bll_flywheel_o <= 1'b0;
      bll_lock_ext_o <= 1'b0;
      bll_lock_video_o <= 1'b0;
      out_tristate_o <= 1'b1;
      out_hold_o <= 1'b0;
      out_force_blue_o <= 1'b0;
      out_force_color_o <= 1'b0;
    end else begin
      sm_reset_o <= sm_reset_next;
      sm_flywheel_o <= sm_fly_next;
      sm_lock_ext_o <= sm_ext_next;
      sm_lock_video_o <= sm_vid_next;
      bll_reset_o <= bll_reset_next;
      bll_flywheel_o <= bll_fly_next;
      bll_lock_ext_o <= bll_ext_next;
      bll_lock_video_o <= bll_vid_next;
      out_tristate_o <= tri_next;
      out_hold_o <= hold_next;
      out_force_blue_o <= blue_next;
      out_force_color_o <= color_next;
    end
  end

  // ---------------------------------------------------------------
  // grab trigger, syncs and settings
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      grab_trigger_o <= 1'b0;
    end else begin
      grab_trigger_o <= run & action_fall & (action_reg == `GDC_ACT_GRAB);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      decoder_line_sync_out_o <= 1'b0;
      decoder_field_sync_out_o <= 1'b0;
      sync_output_disable_o <= 1'b0;
      video_standard_select_o <= `GDC_STD_NTSC;
      toggle_active_o <= 1'b0;
    end else begin
      decoder_line_sync_out_o <= line_sync_i & ~sync_disable_reg & ~tri_next;
      decoder_field_sync_out_o <= field_sync_i & ~sync_disable_reg & ~tri_next;
      sync_output_disable_o <= sync_disable_reg;
      video_standard_select_o <= std_reg;
      toggle_active_o <= toggle_reg;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_stop_low;
    @(posedge clk_i) disable iff (reset_i)
      (!soft_run_bit_reg && !pin_reset_linkage_bit_reg) |=> (sm_reset_o && out_tristate_o);
  endproperty
  a_stop_low: assert property (p_stop_low) else $error("run bit low did not stop");

  property p_run_high;
    @(posedge clk_i) disable iff (reset_i)
      (soft_run_bit_reg && reset_pin_s && action_pin_s && action_reg != `GDC_ACT_TOGGLE)
        |=> (!sm_reset_o && !out_tristate_o);
  endproperty
  a_run_high: assert property (p_run_high) else $error("run bit high did not run");

  property p_bit_ignored;
    @(posedge clk_i) disable iff (reset_i)
      (pin_reset_linkage_bit_reg && reset_pin_s && !soft_run_bit_reg && action_pin_s
        && action_reg != `GDC_ACT_TOGGLE) |=> !sm_reset_o;
  endproperty
  a_bit_ignored: assert property (p_bit_ignored) else $error("run bit not ignored");

  property p_pin_forces;
    @(posedge clk_i) disable iff (reset_i)
      (pin_reset_linkage_bit_reg && !reset_pin_s) |=> (!soft_run_bit_reg && sm_reset_o);
  endproperty
  a_pin_forces: assert property (p_pin_forces) else $error("reset pin did not force");

  property p_stay_stopped;
    @(posedge clk_i) disable iff (reset_i)
      (!pin_reset_linkage_bit_reg && $rose(reset_pin_s) && !(wr_i && gdc_is_ctrl(addr_i)))
        |=> sm_reset_o [*2];
  endproperty
  a_stay_stopped: assert property (p_stay_stopped) else $error("restarted without write");

  property p_auto_restart;
    @(posedge clk_i) disable iff (reset_i)
      (pin_reset_linkage_bit_reg && $rose(reset_pin_s) && action_pin_s && action_reg != `GDC_ACT_TOGGLE)
        |=> !sm_reset_o;
  endproperty
  a_auto_restart: assert property (p_auto_restart) else $error("no restart on pin release");

  property p_reset_all;
    @(posedge clk_i) disable iff (reset_i)
      (run && !action_pin_s && action_reg == `GDC_ACT_RESET_ALL)
        |=> (out_tristate_o && sm_reset_o && bll_reset_o);
  endproperty
  a_reset_all: assert property (p_reset_all) else $error("code 000 wrong");

  property p_reset_bll;
    @(posedge clk_i) disable iff (reset_i)
      (run && !action_pin_s && action_reg == `GDC_ACT_RESET_BLL) |=> (bll_reset_o && !sm_reset_o);
  endproperty
  a_reset_bll: assert property (p_reset_bll) else $error("code 011 wrong");

  property p_toggle;
    @(posedge clk_i) disable iff (reset_i)
      (run && action_fall && action_reg == `GDC_ACT_TOGGLE) |=> (toggle_reg != $past(toggle_reg));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not flip");

  property p_sync_off;
    @(posedge clk_i) disable iff (reset_i)
      sync_disable_reg |=> (!decoder_line_sync_out_o && !decoder_field_sync_out_o);
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync not disabled");

  property p_one_pulse;
    @(posedge clk_i) disable iff (reset_i)
      action_fall |=> !action_fall;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("edge counted twice");

  c_toggle_on: cover property (@(posedge clk_i) disable iff (reset_i) $rose(toggle_active_o));
  c_grab: cover property (@(posedge clk_i) disable iff (reset_i) grab_trigger_o);
  c_pin_reset: cover property (@(posedge clk_i) disable iff (reset_i)
    pin_reset_linkage_bit_reg && $rose(reset_pin_s));

endmodule // gdc_global_ctrl

`default_nettype wire

//--- tb/gdc_host_model.sv
// Purpose: host processor model driving the control port and the two pins
// Assumes: register port strobes are one cycle, read data the cycle after
// Notes: all signals change by non-blocking assignment after a rising edge
`timescale 1ns/1ps
`default_nettype none

module gdc_host_model (
  // clock
  input wire logic clk_i,
  // register port
  output logic [7:0] addr_o,
  output logic [7:0] wr_data_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [7:0] rd_data_i,
  // device pins
  output logic reset_pin_n_o,
  output logic action_pin_n_o
);
  // ---------------------------------------------------------------
  // idle state
  // ---------------------------------------------------------------
  initial begin
    addr_o = 8'h00;
    wr_data_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    reset_pin_n_o = 1'b1;
    action_pin_n_o = 1'b1;
  end

  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    // reserved standard code never written
    wr_data_o <= (d[1:0] == 2'h1) ? {d[7:2], 2'h3} : d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wr_data_o <= ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1 d = rd_data_i;
  endtask

  // ---------------------------------------------------------------
  // pins
  // ---------------------------------------------------------------
  task automatic set_reset_pin(input logic v);
    @(posedge clk_i);
    reset_pin_n_o <= v;
  endtask

  task automatic set_action_pin(input logic v);
    @(posedge clk_i);
    action_pin_n_o <= v;
  endtask

  // low and high long enough for the synchroniser
  task automatic pulse_action();
    set_action_pin(1'b0);
    repeat (4) @(posedge clk_i);
    set_action_pin(1'b1);
    repeat (4) @(posedge clk_i);
  endtask
endmodule // gdc_host_model

`default_nettype wire

//--- tb/gdc_global_ctrl_tb_top.sv
// Purpose: self-checking bench of the decoder global control block
// Assumes: 50 MHz clock, synchronous active-high reset
// Notes: random register values from a fixed seed plus corner cases
`timescale 1ns/1ps
`default_nettype none

module gdc_global_ctrl_tb_top;
  import gdc_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic clk_i, reset_i, ycbcr_mode_i, line_sync_i, field_sync_i;
  wire logic [7:0] addr, wr_data, rd_data;
  wire logic wr, rd, rst_pin_n, act_pin_n;
  wire logic sm_rst, sm_fly, sm_ext, sm_vid, bll_rst, bll_fly, bll_ext, bll_vid;
  wire logic tri_o, hold_o, blue_o, color_o, grab_o, lsync_o, fsync_o, dis_o, tog_o;
  wire logic [1:0] std_o;
  wire logic [11:0] ctl = {sm_rst, sm_fly, sm_ext, sm_vid, bll_rst, bll_fly, bll_ext, bll_vid,
                           tri_o, hold_o, blue_o, color_o};
  localparam logic [11:0] STOP = 12'h808;
  int n_errors = 0;
  int checked = 0;
  int grabs = 0;
  int seed;
  int g0;
  int i;
  logic [7:0] d, rdv;
  logic [31:0] v;
  logic [2:0] c;
  logic y;

  gdc_host_model host (.clk_i(clk_i), .addr_o(addr), .wr_data_o(wr_data), .wr_o(wr), .rd_o(rd),
    .rd_data_i(rd_data), .reset_pin_n_o(rst_pin_n), .action_pin_n_o(act_pin_n));

  gdc_global_ctrl DUT (.clk_i(clk_i), .reset_i(reset_i), .addr_i(addr), .wr_data_i(wr_data),
    .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data), .reset_pin_n_i(rst_pin_n),
    .action_pin_n_i(act_pin_n), .ycbcr_mode_i(ycbcr_mode_i), .line_sync_i(line_sync_i),
    .field_sync_i(field_sync_i), .sm_reset_o(sm_rst), .sm_flywheel_o(sm_fly),
    .sm_lock_ext_o(sm_ext), .sm_lock_video_o(sm_vid), .bll_reset_o(bll_rst),
    .bll_flywheel_o(bll_fly), .bll_lock_ext_o(bll_ext), .bll_lock_video_o(bll_vid),
    .out_tristate_o(tri_o), .out_hold_o(hold_o), .out_force_blue_o(blue_o),
    .out_force_color_o(color_o), .grab_trigger_o(grab_o), .decoder_line_sync_out_o(lsync_o),
    .decoder_field_sync_out_o(fsync_o), .sync_output_disable_o(dis_o),
    .video_standard_select_o(std_o), .toggle_active_o(tog_o));

  // ---------------------------------------------------------------
  // clock, grab counting, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    if (grab_o === 1'b1) grabs <= grabs + 1;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [11:0] exp_act(input logic [2:0] code, input logic ycc);
    case (code)
      3'h0: exp_act = 12'h888;
      3'h1: exp_act = 12'h440 | {10'h0, ~ycc, ycc};
      3'h2: exp_act = 12'h224;
      3'h3: exp_act = 12'h080;
      3'h4: exp_act = 12'h880;
      3'h5: exp_act = 12'h112;
      default: exp_act = 12'h000;
    endcase
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic finish_test();
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'hc9f78479;
    reset_i = 1'b1;
    ycbcr_mode_i = 1'b0;
    line_sync_i = 1'b0;
    field_sync_i = 1'b0;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    settle(1);
    check(16'(ctl), 16'(STOP));
    host.read_reg(8'h00, rdv);
    check(16'(rdv), 16'h0000);
    // random settings while running
    for (i = 0; i < 12; i++) begin
      v = $random(seed);
      d = {2'b10, v[5:0]};
      if (d[1:0] == 2'h1) d[1:0] = 2'h3;
      host.write_reg(8'h00, d);
      line_sync_i <= v[8];
      field_sync_i <= v[9];
      ycbcr_mode_i <= v[10];
      settle(3);
      check(16'(ctl), 16'h0000);
      check(16'(dis_o), 16'(d[2]));
      check(16'(std_o), 16'(d[1:0]));
      check(16'(lsync_o), 16'(v[8] & ~d[2]));
      check(16'(fsync_o), 16'(v[9] & ~d[2]));
      host.read_reg(8'h00, rdv);
      check(16'(rdv), 16'(d));
    end
    // random unmapped address: write must not reach the control register
    d = v[15:8] | 8'h01;
    host.write_reg(d, 8'h00);
    host.read_reg(d, rdv);
    check(16'(rdv), 16'h0000);
    settle(2);
    check(16'(ctl), 16'h0000);
    @(posedge clk_i);
    line_sync_i <= 1'b1;
    host.write_reg(8'h00, 8'h00);
    settle(3);
    check(16'(ctl), 16'(STOP));
    check(16'(lsync_o), 16'h0000);
    // pin reset linkage
    host.write_reg(8'h00, 8'h40);
    settle(3);
    check(16'(ctl), 16'h0000);
    host.set_reset_pin(1'b0);
    settle(5);
    check(16'(ctl), 16'(STOP));
    host.read_reg(8'h00, rdv);
    check(16'(rdv), 16'h0040);
    host.set_reset_pin(1'b1);
    settle(5);
    check(16'(ctl), 16'h0000);
    host.write_reg(8'h00, 8'h80);
    host.set_reset_pin(1'b0);
    settle(5);
    check(16'(ctl), 16'(STOP));
    host.set_reset_pin(1'b1);
    settle(5);
    check(16'(ctl), 16'(STOP));
    host.write_reg(8'h00, 8'h80);
    settle(3);
    check(16'(ctl), 16'h0000);
    // every level action code, then grab
    for (i = 0; i < 7; i++) begin
      c = 3'(i);
      y = v[i];
      @(posedge clk_i);
      ycbcr_mode_i <= (c == 3'h1) ? y : 1'b0;
      host.write_reg(8'h00, {2'b10, c, 3'b000});
      g0 = grabs;
      host.set_action_pin(1'b0);
      settle(5);
      check(16'(ctl), 16'(exp_act(c, y)));
      host.set_action_pin(1'b1);
      settle(5);
      check(16'(ctl), 16'h0000);
      check(16'(grabs - g0), 16'(c == 3'h6));
    end
    // toggle mode
    host.write_reg(8'h00, 8'hb8);
    for (i = 0; i < 3; i++) begin
      host.pulse_action();
      check(16'(tog_o), 16'(i[0] == 1'b0));
      check(16'(ctl), i[0] ? 16'h0000 : 16'(exp_act(3'h2, 1'b0)));
    end
    host.write_reg(8'h00, 8'h38);
    host.write_reg(8'h00, 8'hb8);
    settle(3);
    check(16'(tog_o), 16'h0000);
    host.pulse_action();
    check(16'(tog_o), 16'h0001);
    // mid-run reset while toggled and running
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    settle(1);
    check(16'(ctl), 16'(STOP));
    check(16'(tog_o), 16'h0000);
    host.read_reg(8'h00, rdv);
    check(16'(rdv), 16'h0000);
    finish_test();
  end
endmodule // gdc_global_ctrl_tb_top

`default_nettype wire
